// *** verilog/pceint_top.sv ***
// Purpose: Pin edge change interrupt unit with AHB-Lite register slave
// Assumes: Single 200 MHz clock, async active-high reset, word accesses
// Notes:   Zero wait states; every access answers OKAY
//
// The address map and register access over AHB-Lite were chosen for this implementation.

`timescale 1ns/1ps

module pceint_top
  import pceint_pkg::*;
(
  input  wire logic                        i_mclk,
  input  wire logic                        i_rst,
  input  wire logic [PCEINT_NPINS-1:0]     i_pins,
  input  wire logic                        i_hsel,
  input  wire logic [31:0]                 i_haddr,
  input  wire logic [1:0]                  i_htrans,
  input  wire logic                        i_hwrite,
  input  wire logic [2:0]                  i_hsize,
  input  wire logic [31:0]                 i_hwdata,
  input  wire logic                        i_hready,
  output logic      [31:0]                 o_hrdata,
  output logic                             o_hreadyout,
  output logic                             o_hresp,
  output logic                             o_irq,
  output logic                             o_wake
);
  import pceint_pkg::*;

  // ----------------------------------------
  // Edge detection
  // ----------------------------------------
  pceint_edge_if edge_bus ();

  pceint_edge_det u_det (
    .i_mclk   (i_mclk),
    .i_rst    (i_rst),
    .i_pins   (i_pins),
    .edge_bus (edge_bus)
  );

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [PCEINT_NPINS-1:0] rise_en_r;
  logic [PCEINT_NPINS-1:0] fall_en_r;
  logic [PCEINT_NPINS-1:0] flags_r;
  logic [PCEINT_NPINS-1:0] flags_nxt;
  logic                    master_en_r;
  logic                    sleep_r;
  logic [PCEINT_NPINS-1:0] hit;
  logic                    summary;

  // ----------------------------------------
  // AHB-Lite address phase capture
  // ----------------------------------------
  logic                       wr_pend_r;
  logic [PCEINT_ADDR_W-1:0]   wr_addr_r;
  logic                       rd_req;
  logic                       wr_req;
  logic [PCEINT_ADDR_W-1:0]   req_addr;

  assign req_addr = i_haddr[PCEINT_ADDR_W-1:0];
  assign rd_req = i_hsel & i_hready & ~i_hwrite &
                  ((i_htrans == PCEINT_HTRANS_NONSEQ) | (i_htrans == PCEINT_HTRANS_SEQ));
  assign wr_req = i_hsel & i_hready & i_hwrite &
                  ((i_htrans == PCEINT_HTRANS_NONSEQ) | (i_htrans == PCEINT_HTRANS_SEQ));

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= '0;
    end else begin
      wr_pend_r <= wr_req;
      wr_addr_r <= req_addr;
    end
  end

  // Write data arrives in the data phase; decode there
  logic wr_rise;
  logic wr_fall;
  logic wr_flags;
  logic wr_ictl;
  logic wr_sleep;

  assign wr_rise  = wr_pend_r & (wr_addr_r == PCEINT_OFS_RISE);
  assign wr_fall  = wr_pend_r & (wr_addr_r == PCEINT_OFS_FALL);
  assign wr_flags = wr_pend_r & (wr_addr_r == PCEINT_OFS_FLAGS);
  assign wr_ictl  = wr_pend_r & (wr_addr_r == PCEINT_OFS_ICTL);
  assign wr_sleep = wr_pend_r & (wr_addr_r == PCEINT_OFS_SLEEP);

  // ----------------------------------------
  // Edge enables, bits 7 and 6 not stored
  // ----------------------------------------
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      rise_en_r <= PCEINT_RST_PINS;
      fall_en_r <= PCEINT_RST_PINS;
    end else begin
      if (wr_rise) begin
        rise_en_r <= i_hwdata[PCEINT_NPINS-1:0];
      end
      if (wr_fall) begin
        fall_en_r <= i_hwdata[PCEINT_NPINS-1:0];
      end
    end
  end

  // ----------------------------------------
  // Control: master enable and sleep state
  // ----------------------------------------
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      master_en_r <= 1'b0;
      sleep_r     <= 1'b0;
    end else begin
      if (wr_ictl) begin
        master_en_r <= i_hwdata[PCEINT_ICTL_MEN];
      end
      if (o_wake) begin
        sleep_r <= 1'b0;
      end else if (wr_sleep) begin
        sleep_r <= i_hwdata[0];
      end
    end
  end

  // ----------------------------------------
  // Qualified edges and sticky flags
  // ----------------------------------------
  // Detection runs regardless of master enable or sleep
  assign hit = (edge_bus.rise_evt & rise_en_r)
             | (edge_bus.fall_evt & fall_en_r);

  always_comb begin
    flags_nxt = flags_r;
    if (wr_flags) begin
      flags_nxt = flags_r & i_hwdata[PCEINT_NPINS-1:0];
    end
    flags_nxt = flags_nxt | hit;
  end

  // Flag only rises on a qualified edge, so zero means none since clear
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      flags_r <= PCEINT_RST_PINS;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  assign summary = |flags_r;

  // ----------------------------------------
  // Interrupt and wake outputs
  // ----------------------------------------
  // Wake follows the flag, so the flag is visible before the core resumes
  assign o_irq  = summary & master_en_r;
  assign o_wake = sleep_r & summary & master_en_r;

  // ----------------------------------------
  // Read data, registered for the data phase
  // ----------------------------------------
  logic [31:0] rdata_nxt;

  always_comb begin
    rdata_nxt = PCEINT_RDATA_ZERO;
    if (rd_req) begin
      unique case (req_addr)
        PCEINT_OFS_RISE:  rdata_nxt[PCEINT_NPINS-1:0] = rise_en_r;
        PCEINT_OFS_FALL:  rdata_nxt[PCEINT_NPINS-1:0] = fall_en_r;
        PCEINT_OFS_FLAGS: rdata_nxt[PCEINT_NPINS-1:0] = flags_nxt;
        PCEINT_OFS_ICTL: begin
          rdata_nxt[PCEINT_ICTL_MEN] = master_en_r;
          rdata_nxt[PCEINT_ICTL_SUM] = |flags_nxt;
        end
        PCEINT_OFS_SLEEP: rdata_nxt[0] = sleep_r;
        default:          rdata_nxt = PCEINT_RDATA_ZERO;
      endcase
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_hrdata <= PCEINT_RDATA_ZERO;
    end else begin
      o_hrdata <= rdata_nxt;
    end
  end

  // Zero wait states; size and unmapped addresses still answer OKAY
  assign o_hreadyout = 1'b1;
  assign o_hresp     = 1'b0;

endmodule

// *** include/pceint_pkg.sv ***
// Purpose: Shared constants for the pin edge change interrupt block
// Assumes: 32-bit AHB-Lite register bus, one word per register
// Notes:   Byte offsets are chosen locally; no offsets are printed

package pceint_pkg;

  // ----------------------------------------
  // Sizes
  // ----------------------------------------
  localparam int unsigned PCEINT_NPINS    = 6;
  localparam int unsigned PCEINT_REG_W    = 8;
  localparam int unsigned PCEINT_SYNC_N   = 2;

  // ----------------------------------------
  // Register map, byte addresses
  // ----------------------------------------
  localparam logic [7:0] PCEINT_OFS_RISE  = 8'h00;
  localparam logic [7:0] PCEINT_OFS_FALL  = 8'h04;
  localparam logic [7:0] PCEINT_OFS_FLAGS = 8'h08;
  localparam logic [7:0] PCEINT_OFS_ICTL  = 8'h0c;
  localparam logic [7:0] PCEINT_OFS_SLEEP = 8'h10;
  localparam int unsigned PCEINT_ADDR_W   = 8;

  // ----------------------------------------
  // Field positions in interrupt_control
  // ----------------------------------------
  localparam int unsigned PCEINT_ICTL_SUM = 0;
  localparam int unsigned PCEINT_ICTL_MEN = 3;

  // ----------------------------------------
  // Reset values and bus encodings
  // ----------------------------------------
  localparam logic [PCEINT_NPINS-1:0] PCEINT_RST_PINS = 6'h00;
  localparam logic [31:0] PCEINT_RDATA_ZERO = 32'h0000_0000;
  localparam logic [1:0]  PCEINT_HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0]  PCEINT_HTRANS_SEQ    = 2'h3;

  typedef enum logic [1:0] {
    PCEINT_REG_NONE,
    PCEINT_REG_WR,
    PCEINT_REG_RD
  } pceint_acc_t;

endpackage

// *** include/pceint_edge_if.sv ***
// Purpose: Carries synchronised pin state and edge pulses between modules
// Assumes: Single clock domain
// Notes:   Detector drives, register file listens

`timescale 1ns/1ps

interface pceint_edge_if;
  import pceint_pkg::*;

  logic [PCEINT_NPINS-1:0] level;
  logic [PCEINT_NPINS-1:0] rise_evt;
  logic [PCEINT_NPINS-1:0] fall_evt;

  modport det (output level, output rise_evt, output fall_evt);
  modport reg_side (input level, input rise_evt, input fall_evt);
endinterface

// *** verilog/pceint_edge_det.sv ***
// Purpose: Synchronise port pins and detect raw rising and falling edges
// Assumes: Pins are asynchronous to i_mclk
// Notes:   First sync stage feeds only the second stage

`timescale 1ns/1ps

module pceint_edge_det
  import pceint_pkg::*;
(
  input  wire logic                        i_mclk,
  input  wire logic                        i_rst,
  input  wire logic [PCEINT_NPINS-1:0]     i_pins,
  pceint_edge_if.det                       edge_bus
);

  // ----------------------------------------
  // Two-stage synchroniser and previous sample
  // ----------------------------------------
  logic [PCEINT_NPINS-1:0] sync1_r;
  logic [PCEINT_NPINS-1:0] sync2_r;
  logic [PCEINT_NPINS-1:0] prev_r;

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      sync1_r <= PCEINT_RST_PINS;
      sync2_r <= PCEINT_RST_PINS;
      prev_r  <= PCEINT_RST_PINS;
    end else begin
      sync1_r <= i_pins;
      sync2_r <= sync1_r;
      prev_r  <= sync2_r;
    end
  end

  // ----------------------------------------
  // Per-pin edge compare
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < PCEINT_NPINS; g++) begin : g_pin
      assign edge_bus.rise_evt[g] = sync2_r[g] & ~prev_r[g];
      assign edge_bus.fall_evt[g] = ~sync2_r[g] & prev_r[g];
    end
  endgenerate

  assign edge_bus.level = sync2_r;

endmodule

// *** tb/pceint_checker.sv ***
// Purpose: Port-level assertions for the change interrupt unit
// Assumes: Zero-wait bus, flags visible through o_irq, o_wake and read data
// Notes:   Bound to pceint_top below
`timescale 1ns/1ps
module pceint_checker
  import pceint_pkg::*;
(
  input wire logic                    i_mclk,
  input wire logic                    i_rst,
  input wire logic [PCEINT_NPINS-1:0] i_pins,
  input wire logic                    i_hsel,
  input wire logic [1:0]              i_htrans,
  input wire logic                    i_hwrite,
  input wire logic                    i_hready,
  input wire logic [31:0]             o_hrdata,
  input wire logic                    o_hreadyout,
  input wire logic                    o_hresp,
  input wire logic                    o_irq,
  input wire logic                    o_wake
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  // ----------------------------------------
  // Data phase trackers
  // ----------------------------------------
  logic wr_r;
  logic rd_r;
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      wr_r <= 1'b0;
      rd_r <= 1'b0;
    end else begin
      wr_r <= i_hsel && i_hready && i_htrans[1] && i_hwrite;
      rd_r <= i_hsel && i_hready && i_htrans[1] && !i_hwrite;
    end
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  a_bus_okay: assert property (o_hreadyout && !o_hresp)
    else $error("bus not ready or not okay");
  a_rdata_upper: assert property (o_hrdata[31:6] == 26'h0)
    else $error("unimplemented read bits set");
  a_rdata_idle: assert property (!rd_r |-> o_hrdata == PCEINT_RDATA_ZERO)
    else $error("read data outside data phase");
  a_reset_quiet: assert property ($fell(i_rst) |-> !o_irq && !o_wake)
    else $error("request active after reset");
  a_irq_sticky: assert property (o_irq && !wr_r |=> o_irq)
    else $error("request dropped without a write");
  // Flag lands two edges after the pin reaches the first flop
  a_irq_cause: assert property ($rose(o_irq) |-> $past(wr_r) || $past(i_pins, 3) != $past(i_pins, 4))
    else $error("request rose without edge or write");
  a_wake_pulse: assert property (o_wake |=> !o_wake)
    else $error("wake held too long");
  a_wake_gated: assert property (o_wake |-> o_irq)
    else $error("wake without enabled request");
  cover property ($rose(o_irq));
  cover property (o_wake);
  cover property (rd_r && o_hrdata != 32'h0);
endmodule

bind pceint_top pceint_checker u_chk (.i_mclk(i_mclk), .i_rst(i_rst), .i_pins(i_pins), .i_hsel(i_hsel),
  .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hready(i_hready), .o_hrdata(o_hrdata),
  .o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .o_irq(o_irq), .o_wake(o_wake));

// *** tb/pceint_pin_model.sv ***
// Purpose: External signal source for the six port pins
// Assumes: Sources are set by the bench and retimed to the falling edge of i_mclk
// Notes:   Levels move on the falling edge, clear of sampling
`timescale 1ns/1ps
module pceint_pin_model
  import pceint_pkg::*;
(
  input  wire logic                    i_mclk,
  input  wire logic [PCEINT_NPINS-1:0] i_level,
  output logic      [PCEINT_NPINS-1:0] o_pins
);
  initial o_pins = '0;
  always @(negedge i_mclk) o_pins <= i_level;
endmodule

// *** tb/pin_edge_change_interrupt_tb.sv ***
// Purpose: Self-checking bench for the change interrupt unit
// Assumes: Zero-wait AHB-Lite slave, word accesses only
// Notes:   Expectations follow the enable and flag rules
`timescale 1ns/1ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin err_total++; \
  $display("ERROR %s exp %h got %h", n, e, g); end end
module pin_edge_change_interrupt_tb;
  import pceint_pkg::*;
  logic        i_mclk, i_rst, i_hsel, i_hwrite, hready, o_hreadyout, o_hresp, o_irq, o_wake;
  logic [1:0]  i_htrans;
  logic [2:0]  i_hsize;
  logic [31:0] i_haddr, i_hwdata, o_hrdata, rdv;
  logic [5:0]  lvl, pins;
  int          err_total, samples_checked;
  assign hready = o_hreadyout;
  pceint_top dut (.i_mclk(i_mclk), .i_rst(i_rst), .i_pins(pins), .i_hsel(i_hsel), .i_haddr(i_haddr),
    .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hsize(i_hsize), .i_hwdata(i_hwdata), .i_hready(hready),
    .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .o_irq(o_irq), .o_wake(o_wake));
  pceint_pin_model u_pins (.i_mclk(i_mclk), .i_level(lvl), .o_pins(pins));
  initial begin
    i_mclk = 1'b0;
    forever #2.5 i_mclk = ~i_mclk;
  end
  // ----------------------------------------
  // Bus and pin helpers
  // ----------------------------------------
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_mclk);
    i_hsel <= 1'b1;
    i_haddr <= {24'h0, a};
    i_hwrite <= w;
    i_htrans <= PCEINT_HTRANS_NONSEQ;
    @(posedge i_mclk);
    while (hready !== 1'b1) @(posedge i_mclk);
    i_hsel <= 1'b0;
    i_htrans <= 2'h0;
    i_hwdata <= d;
    @(posedge i_mclk);
    while (hready !== 1'b1) @(posedge i_mclk);
    rdv = o_hrdata;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
    bus(1'b0, a, 32'h0);
    `CHK(n, e, rdv)
  endtask
  task automatic pin(input logic [5:0] v);
    @(posedge i_mclk);
    lvl <= v;
    repeat (5) @(posedge i_mclk);
  endtask
  // Wake is a one-cycle pulse, so poll every falling edge
  task automatic wake_chk(input logic e);
    for (int i = 0; i < 8 && o_wake !== 1'b1; i++) @(negedge i_mclk);
    `CHK("wake", e, o_wake)
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    rd(PCEINT_OFS_RISE, 32'h0, "rise");
    rd(PCEINT_OFS_FALL, 32'h0, "fall");
    rd(PCEINT_OFS_FLAGS, 32'h0, "flags");
    rd(PCEINT_OFS_ICTL, 32'h0, "ictl");
    rd(8'h14, 32'h0, "unmapped");
  endtask
  task automatic t_bits();
    bus(1'b1, PCEINT_OFS_RISE, 32'hffff_ffff);
    rd(PCEINT_OFS_RISE, 32'h3f, "rise");
    bus(1'b1, PCEINT_OFS_FALL, 32'hff);
    rd(PCEINT_OFS_FALL, 32'h3f, "fall");
    bus(1'b1, PCEINT_OFS_FLAGS, 32'hff);
    rd(PCEINT_OFS_FLAGS, 32'h0, "flags");
    bus(1'b1, PCEINT_OFS_ICTL, 32'hff);
    rd(PCEINT_OFS_ICTL, 32'h08, "ictl");
  endtask
  task automatic t_edges();
    bus(1'b1, PCEINT_OFS_ICTL, 32'h0);
    bus(1'b1, PCEINT_OFS_RISE, 32'h21);
    bus(1'b1, PCEINT_OFS_FALL, 32'h22);
    pin(6'h03);
    rd(PCEINT_OFS_FLAGS, 32'h01, "flags");
    pin(6'h00);
    rd(PCEINT_OFS_FLAGS, 32'h03, "flags");
    pin(6'h20);
    bus(1'b1, PCEINT_OFS_FLAGS, 32'h03);
    rd(PCEINT_OFS_FLAGS, 32'h03, "flags");
    pin(6'h04);
    rd(PCEINT_OFS_FLAGS, 32'h23, "flags");
    @(negedge i_mclk);
    `CHK("irq", 1'b0, o_irq)
    rd(PCEINT_OFS_ICTL, 32'h01, "ictl");
    bus(1'b1, PCEINT_OFS_ICTL, 32'h08);
    // Enable lands on the edge the task returns at; look once it settles
    @(negedge i_mclk);
    `CHK("irq", 1'b1, o_irq)
  endtask
  task automatic t_clear();
    bus(1'b0, PCEINT_OFS_FLAGS, 32'h0);
    bus(1'b1, PCEINT_OFS_FLAGS, rdv ^ 32'hff);
    rd(PCEINT_OFS_ICTL, 32'h08, "ictl");
    @(negedge i_mclk);
    `CHK("irq", 1'b0, o_irq)
  endtask
  // Pin lands on the same edge as the flag write
  task automatic t_race();
    pin(6'h05);
    @(posedge i_mclk);
    lvl <= 6'h25;
    bus(1'b1, PCEINT_OFS_FLAGS, 32'h0);
    rd(PCEINT_OFS_FLAGS, 32'h20, "flags");
  endtask
  task automatic t_sleep();
    bus(1'b1, PCEINT_OFS_FLAGS, 32'h0);
    bus(1'b1, PCEINT_OFS_SLEEP, 32'h1);
    @(posedge i_mclk);
    lvl <= 6'h05;
    wake_chk(1'b1);
    rd(PCEINT_OFS_FLAGS, 32'h20, "flags");
    rd(PCEINT_OFS_SLEEP, 32'h0, "sleep");
    bus(1'b1, PCEINT_OFS_FLAGS, 32'h0);
    bus(1'b1, PCEINT_OFS_ICTL, 32'h0);
    bus(1'b1, PCEINT_OFS_SLEEP, 32'h1);
    @(posedge i_mclk);
    lvl <= 6'h25;
    wake_chk(1'b0);
    rd(PCEINT_OFS_FLAGS, 32'h20, "flags");
  endtask
  task automatic report_and_stop();
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    #50000;
    err_total++;
    report_and_stop();
  end
  initial begin
    i_rst = 1'b1;
    i_hsel = 1'b0;
    i_hwrite = 1'b0;
    i_htrans = 2'h0;
    i_hsize = 3'h2;
    i_haddr = 32'h0;
    i_hwdata = 32'h0;
    lvl = 6'h00;
    err_total = 0;
    samples_checked = 0;
    repeat (20) @(posedge i_mclk);
    i_rst <= 1'b0;
    t_reset();
    t_bits();
    t_edges();
    t_clear();
    t_race();
    t_sleep();
    report_and_stop();
  end
endmodule
